// File: verilog/esa6_cfg.svh
/*
  Constants for the Sa6 pattern interrupt block: register offsets, field positions,
  reset values and pattern codes.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ESA6_CFG_SVH
`define ESA6_CFG_SVH

// register indices as printed, byte address is four times the index
`define ESA6_IDX_STATUS 16'h0B0C
`define ESA6_IDX_ENABLE 16'h0B0D
`define ESA6_ADDR_W 18
`define ESA6_ADDR_STATUS 18'h02C30
`define ESA6_ADDR_ENABLE 18'h02C34

// flag indices 3 to 0 for 1111, 1110, 1100 and 1010; the status and enable registers share the positions below
`define ESA6_BIT_1111 3
`define ESA6_BIT_1110 2
`define ESA6_BIT_1100 1
`define ESA6_BIT_1010 0

`define ESA6_POS_1111 7
`define ESA6_POS_1110 6
`define ESA6_POS_1100 5
`define ESA6_POS_1010 4
`define ESA6_POS_1000 3
`define ESA6_POS_001X 2
`define ESA6_POS_OTHER 1
`define ESA6_POS_0000 0

// pattern codes
`define ESA6_PAT_1111 4'hF
`define ESA6_PAT_1110 4'hE
`define ESA6_PAT_1100 4'hC
`define ESA6_PAT_1010 4'hA
`define ESA6_PAT_1000 4'h8
`define ESA6_PAT_001X 3'h1
`define ESA6_PAT_0000 4'h0

`define ESA6_FLAGS_RST 8'h00
`define ESA6_FLAG_RST 1'b0
`define ESA6_ENBIT_RST 1'b0
`define ESA6_ENABLE_RST 8'h00
`define ESA6_NIBBLE_RST 4'h0
`define ESA6_RDATA_RST 32'h0000_0000
`define ESA6_BUS_IDLE 32'h0000_0000

`endif

// File: verilog/esa6_pkg.sv
/*
  Types for the Sa6 pattern interrupt block.
  Assumes esa6_cfg.svh holds the constants.
*/
`include "esa6_cfg.svh"

package esa6_pkg;

  // one bit per monitored condition, same layout in status and enable
  typedef struct packed {
    logic allOne;
    logic patternE;
    logic patternC;
    logic patternA;
    logic pattern8;
    logic patternTwo;
    logic unlisted;
    logic allZero;
  } esa6_flags_t;

  // avalon-mm slave request
  typedef struct packed {
    logic [`ESA6_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } esa6_req_t;

  // bus answer phase
  typedef enum logic [1:0] {
    ESA6_IDLE = 2'b00,
    ESA6_ANSWER = 2'b01
  } esa6_bus_state_t;

endpackage : esa6_pkg

// File: verilog/esa6_pattern_match.sv
/*
  Compares the debounced Sa6 nibble against every monitored pattern.
  Assumes the nibble is already debounced and in the block's clock domain.
*/
`timescale 1ns/1ps
`include "esa6_cfg.svh"

module esa6_pattern_match
  import esa6_pkg::*;
(
  input wire logic [3:0] nibble,
  output esa6_flags_t match
);

  always_comb begin
    match = '0;
    match.allOne = (nibble == `ESA6_PAT_1111);
    match.patternE = (nibble == `ESA6_PAT_1110);
    match.patternC = (nibble == `ESA6_PAT_1100);
    match.patternA = (nibble == `ESA6_PAT_1010);
    match.pattern8 = (nibble == `ESA6_PAT_1000);
    // last bit ignored
    match.patternTwo = (nibble[3:1] == `ESA6_PAT_001X);
    match.allZero = (nibble == `ESA6_PAT_0000);
    // anything not covered above
    match.unlisted = ~(match.allOne | match.patternE | match.patternC | match.patternA
      | match.pattern8 | match.patternTwo | match.allZero);
  end

endmodule : esa6_pattern_match

// File: verilog/esa6_sa6_interrupts.sv
/*
  Sa6 pattern interrupt logic of one E1 receive channel, with an Avalon-MM slave
  giving access to the status (clear on read) and enable registers.
  Assumes a debounced Sa6 nibble from an upstream stage on the same clock.
*/
// The Avalon-MM slave port is this design's own decision.
//
// Contract
// - set the 001x flag when the nibble starts or stops matching 001x, last bit ignored.
// - a flag reads 1 if its event came since the last status read, which clears it.
// - set the unlisted-value flag when the nibble moves from a listed pattern to a value outside every pattern.
// - set the all-zero flag when the nibble becomes 0000 and when it stops being 0000.
// - enable bit 7 lets the 1111 change raise the interrupt.
// - enable bit 6 lets the 1110 change raise the interrupt.
// - enable bit 5 lets the 1100 change raise the interrupt.
// - an event drives the interrupt only while its enable bit is 1.
// - status bits 7 to 3 hold change flags for 1111, 1110, 1100, 1010 and 1000.
// - enable bits 4 to 0 gate 1010, 1000, 001x, unlisted and 0000, all off after reset.
`timescale 1ns/1ps
`include "esa6_cfg.svh"

module esa6_sa6_interrupts
  import esa6_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sa6Nibble,
  input wire logic [`ESA6_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // pattern detection

  esa6_flags_t matchNow;
  esa6_flags_t match_reg;
  esa6_flags_t status_reg;
  esa6_flags_t status_next;
  esa6_flags_t enable_reg;
  esa6_flags_t event_w;
  logic primed_reg;
  esa6_bus_state_t busState_reg;
  esa6_bus_state_t busState_next;
  esa6_req_t req;
  logic [31:0] avs_readdata_reg;
  logic irq_reg;
  logic statusRead;
  logic enableWrite;
  logic stAllOne_reg;
  logic stPatternE_reg;
  logic stPatternC_reg;
  logic stPatternA_reg;
  logic stPattern8_reg;
  logic stPatternTwo_reg;
  logic stUnlisted_reg;
  logic stAllZero_reg;
  logic enAllOne_reg;
  logic enPatternE_reg;
  logic enPatternC_reg;
  logic enPatternA_reg;
  logic enPattern8_reg;
  logic enPatternTwo_reg;
  logic enUnlisted_reg;
  logic enAllZero_reg;

  // upstream debounce already done, compare only
  esa6_pattern_match u_match (
    .nibble(sa6Nibble),
    .match(matchNow)
  );

  function automatic esa6_flags_t change_of(input esa6_flags_t prev, input esa6_flags_t cur);
    change_of = prev ^ cur;
  endfunction : change_of

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_reg <= `ESA6_FLAGS_RST;
      primed_reg <= 1'b0;
    end else begin
      match_reg <= matchNow;
      primed_reg <= 1'b1;
    end
  end

  // first cycle after reset only records the nibble, so reset itself is no change
  always_comb begin
    event_w = '0;
    if (primed_reg) begin
      event_w = change_of(match_reg, matchNow);
      event_w.unlisted = matchNow.unlisted & ~match_reg.unlisted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer on the second edge

  always_comb begin
    req.address = avs_address;
    req.read = avs_read;
    req.write = avs_write;
    req.writedata = avs_writedata;
    req.byteenable = avs_byteenable;
  end

  always_comb begin
    busState_next = ESA6_IDLE;
    if (busState_reg == ESA6_IDLE && (req.read || req.write)) begin
      busState_next = ESA6_ANSWER;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busState_reg <= ESA6_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  assign avs_waitrequest = (req.read || req.write) && (busState_reg != ESA6_ANSWER);

  assign statusRead = (busState_reg == ESA6_ANSWER) && req.read
    && (req.address == `ESA6_ADDR_STATUS);
  assign enableWrite = (busState_reg == ESA6_ANSWER) && req.write
    && (req.address == `ESA6_ADDR_ENABLE) && req.byteenable[0];

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  // a read clears the flags it returned; an event in the same cycle survives
  always_comb begin
    status_next = status_reg;
    if (statusRead) begin
      status_next = `ESA6_FLAGS_RST;
    end
    status_next = status_next | event_w;
  end

  // sticky flag: an event wins over the clearing read
  function automatic logic sticky_next(input logic cur, input logic ev, input logic clr);
    sticky_next = (cur & ~clr) | ev;
  endfunction : sticky_next

  // 1111 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stAllOne_reg <= `ESA6_FLAG_RST;
    end else begin
      stAllOne_reg <= sticky_next(stAllOne_reg, event_w.allOne,
        statusRead);
    end
  end

  // 1110 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stPatternE_reg <= `ESA6_FLAG_RST;
    end else begin
      stPatternE_reg <= sticky_next(stPatternE_reg, event_w.patternE,
        statusRead);
    end
  end

  // 1100 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stPatternC_reg <= `ESA6_FLAG_RST;
    end else begin
      stPatternC_reg <= sticky_next(stPatternC_reg, event_w.patternC,
        statusRead);
    end
  end

  // 1010 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stPatternA_reg <= `ESA6_FLAG_RST;
    end else begin
      stPatternA_reg <= sticky_next(stPatternA_reg, event_w.patternA,
        statusRead);
    end
  end

  // 1000 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stPattern8_reg <= `ESA6_FLAG_RST;
    end else begin
      stPattern8_reg <= sticky_next(stPattern8_reg, event_w.pattern8,
        statusRead);
    end
  end

  // 001x change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stPatternTwo_reg <= `ESA6_FLAG_RST;
    end else begin
      stPatternTwo_reg <= sticky_next(stPatternTwo_reg, event_w.patternTwo,
        statusRead);
    end
  end

  // unlisted value flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stUnlisted_reg <= `ESA6_FLAG_RST;
    end else begin
      stUnlisted_reg <= sticky_next(stUnlisted_reg, event_w.unlisted,
        statusRead);
    end
  end

  // 0000 change flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stAllZero_reg <= `ESA6_FLAG_RST;
    end else begin
      stAllZero_reg <= sticky_next(stAllZero_reg, event_w.allZero,
        statusRead);
    end
  end

  // 1111 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enAllOne_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enAllOne_reg <= req.writedata[`ESA6_POS_1111];
    end
  end

  // 1110 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPatternE_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enPatternE_reg <= req.writedata[`ESA6_POS_1110];
    end
  end

  // 1100 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPatternC_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enPatternC_reg <= req.writedata[`ESA6_POS_1100];
    end
  end

  // 1010 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPatternA_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enPatternA_reg <= req.writedata[`ESA6_POS_1010];
    end
  end

  // 1000 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPattern8_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enPattern8_reg <= req.writedata[`ESA6_POS_1000];
    end
  end

  // 001x enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enPatternTwo_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enPatternTwo_reg <= req.writedata[`ESA6_POS_001X];
    end
  end

  // unlisted value enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enUnlisted_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enUnlisted_reg <= req.writedata[`ESA6_POS_OTHER];
    end
  end

  // 0000 enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enAllZero_reg <= `ESA6_ENBIT_RST;
    end else if (enableWrite) begin
      enAllZero_reg <= req.writedata[`ESA6_POS_0000];
    end
  end

  // flag bits gathered in register layout
  always_comb begin
    status_reg.allOne = stAllOne_reg;
    status_reg.patternE = stPatternE_reg;
    status_reg.patternC = stPatternC_reg;
    status_reg.patternA = stPatternA_reg;
    status_reg.pattern8 = stPattern8_reg;
    status_reg.patternTwo = stPatternTwo_reg;
    status_reg.unlisted = stUnlisted_reg;
    status_reg.allZero = stAllZero_reg;
  end

  // enable bits gathered in register layout
  always_comb begin
    enable_reg.allOne = enAllOne_reg;
    enable_reg.patternE = enPatternE_reg;
    enable_reg.patternC = enPatternC_reg;
    enable_reg.patternA = enPatternA_reg;
    enable_reg.pattern8 = enPattern8_reg;
    enable_reg.patternTwo = enPatternTwo_reg;
    enable_reg.unlisted = enUnlisted_reg;
    enable_reg.allZero = enAllZero_reg;
  end

  // read data: status and enable in the low byte, unmapped reads as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata_reg <= `ESA6_RDATA_RST;
    end else if (busState_reg == ESA6_IDLE && req.read) begin
      unique case (req.address)
        `ESA6_ADDR_STATUS: avs_readdata_reg <= {24'h000000, status_reg | event_w};
        `ESA6_ADDR_ENABLE: avs_readdata_reg <= {24'h000000, enable_reg};
        default: avs_readdata_reg <= `ESA6_BUS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & enable_reg);
    end
  end

  assign avs_readdata = avs_readdata_reg;
  assign irq = irq_reg;

endmodule : esa6_sa6_interrupts

// File: bench/esa6_sa6_interrupts_asserts.sv
/* Assertions on the ports of the Sa6 interrupt block.
   Assumes the bind below and the shared header. */
`timescale 1ns/1ps
`include "esa6_cfg.svh"
module esa6_sa6_checker
  import esa6_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sa6Nibble,
  input wire logic [`ESA6_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  localparam logic [17:0] ST = `ESA6_ADDR_STATUS;
  localparam logic [17:0] EN = `ESA6_ADDR_ENABLE;
  wire logic take = avs_read && avs_waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("second wait cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  data_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (take && avs_address != ST && avs_address != EN
    |=> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  irq_reset_a: assert property ($rose(rst_n) |-> !irq)
    else $error("irq after reset");
  zero_flag_a: assert property (
    $past(rst_n) && (($past(sa6Nibble) == 4'h0) != (sa6Nibble == 4'h0))
    ##1 take && avs_address == ST |=> avs_readdata[0]) else $error("zero flag lost");
  two_flag_a: assert property (
    $past(rst_n) && (($past(sa6Nibble[3:1]) == 3'h1) != (sa6Nibble[3:1] == 3'h1))
    ##1 take && avs_address == ST |=> avs_readdata[2]) else $error("001x flag lost");
  one_flag_a: assert property (
    $past(rst_n) && (($past(sa6Nibble) == 4'hF) != (sa6Nibble == 4'hF))
    ##1 take && avs_address == ST |=> avs_readdata[7]) else $error("1111 flag lost");
  irq_mask_a: assert property (
    avs_write && !avs_waitrequest && avs_address == EN && avs_byteenable[0]
    && avs_writedata[7:0] == 8'h00 |=> ##1 !irq) else $error("irq while disabled");
endmodule : esa6_sa6_checker
bind esa6_sa6_interrupts esa6_sa6_checker chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .sa6Nibble(sa6Nibble),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq)
);

// File: bench/test_e1_sa6_pattern_interrupts.sv
/* Self-checking bench of the Sa6 interrupt block over its Avalon-MM port.
   Assumes the package, header and checker are compiled first. */
`timescale 1ns/1ps
`include "esa6_cfg.svh"
module test_e1_sa6_pattern_interrupts
  import esa6_pkg::*;
;
  localparam logic [17:0] ST = `ESA6_ADDR_STATUS;
  localparam logic [17:0] EN = `ESA6_ADDR_ENABLE;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sa6Nibble = 4'h0;
  logic [17:0] avs_address = 18'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [31:0] q;
  int errTotal = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  esa6_sa6_interrupts dut (
    .clk(clk),
    .rst_n(rst_n),
    .sa6Nibble(sa6Nibble),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    if (n == 16) begin
      errTotal++;
      report_and_stop();
    end
    // read data stand from the edge that ends the wait cycle through the completing edge
    q = avs_readdata;
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic nib(input logic [3:0] v);
    sa6Nibble <= v;
    @(posedge clk);
  endtask : nib
  function automatic logic [7:0] pat(input logic [3:0] v);
    pat = {v == 4'hF, v == 4'hE, v == 4'hC, v == 4'hA, v == 4'h8, v[3:1] == 3'h1, 1'b0, v == 4'h0};
    pat[1] = (pat == 8'h00);
  endfunction : pat
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    @(negedge clk);
    chk("irq", {31'h00000000, irq}, 32'h00000000);
    @(posedge clk);
    bus(1'b0, ST, 8'h00, 4'hF);
    chk("status", q, 32'h00000000);
    bus(1'b0, EN, 8'h00, 4'hF);
    chk("enable", q, 32'h00000000);
  endtask : reset_values
  task automatic enable_access();
    bus(1'b1, EN, 8'h1F, 4'hF);
    bus(1'b0, EN, 8'h00, 4'hF);
    chk("enable", q, 32'h0000001F);
    bus(1'b1, EN, 8'hE0, 4'hF);
    bus(1'b1, EN, 8'h1F, 4'h0);
    bus(1'b1, ST, 8'hFF, 4'hF);
    bus(1'b0, EN, 8'h00, 4'hF);
    chk("enable", q, 32'h000000E0);
    bus(1'b0, 18'h00010, 8'h00, 4'hF);
    chk("unmapped", q, 32'h00000000);
  endtask : enable_access
  task automatic mask_gate();
    bus(1'b1, EN, 8'h20, 4'hF);
    nib(4'hF);
    @(negedge clk);
    chk("irq", {31'h00000000, irq}, 32'h00000000);
    bus(1'b1, EN, 8'h80, 4'hF);
    @(negedge clk);
    chk("irq", {31'h00000000, irq}, 32'h00000001);
    bus(1'b0, ST, 8'h00, 4'hF);
    chk("status", q, 32'h00000081);
    @(negedge clk);
    chk("irq", {31'h00000000, irq}, 32'h00000000);
    bus(1'b1, EN, 8'h00, 4'hF);
  endtask : mask_gate
  task automatic pattern_walk();
    logic [3:0] sq [8] = '{4'hE, 4'hC, 4'hA, 4'h8, 4'h2, 4'h3, 4'h5, 4'h0};
    logic [3:0] p = 4'hF;
    logic [7:0] e;
    foreach (sq[i]) begin
      nib(sq[i]);
      e = (pat(p) ^ pat(sq[i])) & 8'hFD | pat(sq[i]) & ~pat(p) & 8'h02;
      bus(1'b0, ST, 8'h00, 4'hF);
      chk("walk", q, {24'h000000, e});
      p = sq[i];
    end
    bus(1'b0, ST, 8'h00, 4'hF);
    chk("cleared", q, 32'h00000000);
  endtask : pattern_walk
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_values();
    enable_access();
    mask_gate();
    pattern_walk();
    report_and_stop();
  end
endmodule : test_e1_sa6_pattern_interrupts
